// >>> core/ebcs_defines.svh
// constants of the external bus chip select block: offsets, field positions, resets
// assumes a 32-bit register port with byte offsets
`ifndef EBCS_DEFINES_SVH
`define EBCS_DEFINES_SVH

`define EBCS_AW 8
`define EBCS_DW 32
`define EBCS_ADDR_W 24
`define EBCS_NCS 6

`define EBCS_OFF_CFG 8'h00
`define EBCS_OFF_STAT 8'h04
`define EBCS_OFF_MASK 8'h08
`define EBCS_OFF_INFO 8'h0C

`define EBCS_CFG_CS1 1
`define EBCS_CFG_CS2 2
`define EBCS_CFG_CS3 3
`define EBCS_CFG_CS4 4
`define EBCS_CFG_CS5 5
`define EBCS_CFG_WMASK 32'h0000_003E
`define EBCS_CFG_RST 32'h0000_0000

`define EBCS_EV_SDRAM 0
`define EBCS_EV_ECC 1
`define EBCS_EV_SLEEP 2
`define EBCS_EV_CFGBUSY 3
`define EBCS_EV_W 4
`define EBCS_EV_RST 4'h0

`define EBCS_INFO_MAIN_CLK 0
`define EBCS_INFO_SDRAM_CLK 1
`define EBCS_INFO_STATIC_CLK 2
`define EBCS_INFO_ECC_CLK 3
`define EBCS_INFO_ROLE_LSB 4
`define EBCS_INFO_SEL_LSB 8

`define EBCS_CF_IORD_MODE 3'h4

`endif

// >>> core/ebcs_mux.sv
// pin multiplexer of the external bus: routes controller signals per access role
// assumes controllers on the same clock and a role decoded by the caller
`timescale 1ns/100ps
`default_nettype none
`include "ebcs_defines.svh"

module ebcs_mux import ebcs_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic acc_valid,
  input wire ebcs_role_e role,
  input wire logic sdram_en,
  input wire ebcs_smc_s static_memory_ctrl,
  input wire ebcs_sdr_s sdr,
  output var ebcs_pin_s pin_q
);

  ebcs_pin_s pin_d;

  always_comb begin
    pin_d = '1;
    pin_d.addr = pin_q.addr;
    pin_d.sdcke = sdram_en & sdr.cke;
    if (acc_valid) begin
      pin_d.ncs_n = static_memory_ctrl.ncs_n;
      pin_d.rd_n = static_memory_ctrl.rd_n;
      pin_d.we0_n = static_memory_ctrl.we0_n;
      pin_d.we1_n = static_memory_ctrl.we1_n;
      pin_d.addr = static_memory_ctrl.addr;
      case (role)
        EBCS_ROLE_SDRAM: begin
          pin_d.ncs_n[1] = sdr.cs_n;
          pin_d.addr = sdr.addr;
          pin_d.addr[0] = sdr.dqm[0];
          pin_d.we1_n = sdr.dqm[1];
          pin_d.rd_n = 1'b1;
          pin_d.we0_n = 1'b1;
          pin_d.sdwe_n = sdr.we_n;
          pin_d.ras_n = sdr.ras_n;
          pin_d.cas_n = sdr.cas_n;
        end
        EBCS_ROLE_NAND: begin
          pin_d.nand_oe_n = static_memory_ctrl.rd_n;
          pin_d.nand_we_n = static_memory_ctrl.we0_n;
          pin_d.rd_n = 1'b1;
          pin_d.we0_n = 1'b1;
        end
        EBCS_ROLE_CARD: begin
          pin_d.cfce1_n = static_memory_ctrl.addr[0];
          pin_d.cfce2_n = static_memory_ctrl.we1_n;
          pin_d.cfrnw = static_memory_ctrl.we0_n;
          if (ebcs_cf_iord(static_memory_ctrl.addr)) begin
            pin_d.cf_iord_n = static_memory_ctrl.rd_n;
            pin_d.rd_n = 1'b1;
          end
        end
        default: begin
          pin_d.sdwe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= '1;
      pin_q.addr <= '0;
      pin_q.sdcke <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

endmodule

`default_nettype wire

// >>> core/ebcs_pkg.sv
// types of the external bus chip select block
// assumes the constants header is on the include path
`include "ebcs_defines.svh"

package ebcs_pkg;

  typedef enum logic [2:0] {
    EBCS_ROLE_IDLE,
    EBCS_ROLE_STATIC,
    EBCS_ROLE_SDRAM,
    EBCS_ROLE_NAND,
    EBCS_ROLE_CARD
  } ebcs_role_e;

  typedef struct packed {
    logic [`EBCS_NCS-1:0] ncs_n;
    logic rd_n;
    logic we0_n;
    logic we1_n;
    logic [`EBCS_ADDR_W-1:0] addr;
  } ebcs_smc_s;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] dqm;
    logic [`EBCS_ADDR_W-1:0] addr;
  } ebcs_sdr_s;

  typedef struct packed {
    logic [`EBCS_NCS-1:0] ncs_n;
    logic rd_n;
    logic we0_n;
    logic we1_n;
    logic [`EBCS_ADDR_W-1:0] addr;
    logic sdcke;
    logic sdwe_n;
    logic ras_n;
    logic cas_n;
    logic nand_oe_n;
    logic nand_we_n;
    logic cfce1_n;
    logic cfce2_n;
    logic cfrnw;
    logic cf_iord_n;
  } ebcs_pin_s;

  // role of the pins for an access to a chip select
  function automatic ebcs_role_e ebcs_role(input logic [`EBCS_DW-1:0] cfg, input logic [2:0] sel);
    ebcs_role_e r;
    r = EBCS_ROLE_STATIC;
    case (sel)
      3'h1: r = cfg[`EBCS_CFG_CS1] ? EBCS_ROLE_SDRAM : EBCS_ROLE_STATIC;
      3'h2, 3'h3: r = cfg[sel] ? EBCS_ROLE_NAND : EBCS_ROLE_STATIC;
      3'h4, 3'h5: r = cfg[sel] ? EBCS_ROLE_CARD : EBCS_ROLE_STATIC;
      default: r = EBCS_ROLE_STATIC;
    endcase
    return r;
  endfunction

  // card access in i/o read mode
  function automatic logic ebcs_cf_iord(input logic [`EBCS_ADDR_W-1:0] a);
    return a[`EBCS_ADDR_W-1:`EBCS_ADDR_W-3] == `EBCS_CF_IORD_MODE;
  endfunction

endpackage

// >>> core/ebcs_top.sv
// external bus chip select assignment: config register, pin routing, interrupts
// assumes a plain register port and controllers running on clk
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "ebcs_defines.svh"

module ebcs_top import ebcs_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`EBCS_AW-1:0] reg_addr,
  input wire logic [`EBCS_DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [`EBCS_DW-1:0] reg_rdata,
  input wire logic acc_valid,
  input wire logic [2:0] acc_sel,
  input wire ebcs_smc_s smc_sig,
  input wire ebcs_sdr_s sdr_sig,
  input wire logic sdram_src_irq,
  input wire logic ecc_src_irq,
  input wire logic sleep_req,
  output ebcs_pin_s pin_out,
  output logic sdram_enable,
  output logic sdram_ctrl_interrupt,
  output logic ecc_unit_interrupt,
  output logic ext_bus_irq
);

  logic [`EBCS_DW-1:0] cfg_q;
  logic [`EBCS_EV_W-1:0] stat_q;
  logic [`EBCS_EV_W-1:0] stat_d;
  logic [`EBCS_EV_W-1:0] mask_q;
  logic [`EBCS_EV_W-1:0] ev;
  logic [`EBCS_EV_W-1:0] clr;
  logic [`EBCS_DW-1:0] rdata_q;
  logic [`EBCS_DW-1:0] info;
  logic sdram_src_q;
  logic ecc_src_q;
  logic busy_q;
  ebcs_role_e role;
  ebcs_role_e role_q;
  logic [2:0] sel_q;

  wire wr_cfg = reg_we && (reg_addr == `EBCS_OFF_CFG);
  wire wr_stat = reg_we && (reg_addr == `EBCS_OFF_STAT);
  wire wr_mask = reg_we && (reg_addr == `EBCS_OFF_MASK);

  // access role from the assignment bits
  assign role = acc_valid ? ebcs_role(cfg_q, acc_sel) : EBCS_ROLE_IDLE;

  // assignment register: only bits 5..1 are held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= `EBCS_CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata & `EBCS_CFG_WMASK;
    end
  end

  assign sdram_enable = cfg_q[`EBCS_CFG_CS1];

  ebcs_mux u_mux (
    .clk(clk),
    .arst_n(arst_n),
    .acc_valid(acc_valid),
    .role(role),
    .sdram_en(sdram_enable),
    .static_memory_ctrl(smc_sig),
    .sdr(sdr_sig),
    .pin_q(pin_out)
  );

  // bus activity tracking for the sleep and config hazards
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      role_q <= EBCS_ROLE_IDLE;
      sel_q <= 3'h0;
    end else begin
      busy_q <= acc_valid;
      if (acc_valid) begin
        role_q <= role;
        sel_q <= acc_sel;
      end
    end
  end

  // controller interrupt sources, edge detected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdram_src_q <= 1'b0;
      ecc_src_q <= 1'b0;
    end else begin
      sdram_src_q <= sdram_src_irq;
      ecc_src_q <= ecc_src_irq;
    end
  end

  always_comb begin
    ev = '0;
    ev[`EBCS_EV_SDRAM] = sdram_src_irq & ~sdram_src_q;
    ev[`EBCS_EV_ECC] = ecc_src_irq & ~ecc_src_q;
    ev[`EBCS_EV_SLEEP] = sleep_req & (busy_q | acc_valid);
    ev[`EBCS_EV_CFGBUSY] = wr_cfg & (busy_q | acc_valid);
  end

  // write one to clear; a new event wins over the clear
  assign clr = wr_stat ? reg_wdata[`EBCS_EV_W-1:0] : '0;
  assign stat_d = (stat_q & ~clr) | ev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= `EBCS_EV_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= `EBCS_EV_RST;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[`EBCS_EV_W-1:0];
    end
  end

  assign sdram_ctrl_interrupt = stat_q[`EBCS_EV_SDRAM] & mask_q[`EBCS_EV_SDRAM];
  assign ecc_unit_interrupt = stat_q[`EBCS_EV_ECC] & mask_q[`EBCS_EV_ECC];
  assign ext_bus_irq = |(stat_q & mask_q);

  // clock needs and last access role
  always_comb begin
    info = '0;
    info[`EBCS_INFO_MAIN_CLK] = 1'b1;
    info[`EBCS_INFO_SDRAM_CLK] = cfg_q[`EBCS_CFG_CS1];
    info[`EBCS_INFO_STATIC_CLK] = 1'b1;
    info[`EBCS_INFO_ECC_CLK] = cfg_q[`EBCS_CFG_CS2] | cfg_q[`EBCS_CFG_CS3];
    info[`EBCS_INFO_ROLE_LSB +: 3] = role_q;
    info[`EBCS_INFO_SEL_LSB +: 3] = sel_q;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (reg_re) begin
      case (reg_addr)
        `EBCS_OFF_CFG: rdata_q <= cfg_q;
        `EBCS_OFF_STAT: rdata_q <= {{(`EBCS_DW-`EBCS_EV_W){1'b0}}, stat_q};
        `EBCS_OFF_MASK: rdata_q <= {{(`EBCS_DW-`EBCS_EV_W){1'b0}}, mask_q};
        `EBCS_OFF_INFO: rdata_q <= info;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  // checks
  property p_sdram_irq;
    @(posedge clk) disable iff (!arst_n)
    (sdram_src_irq && !sdram_src_q && mask_q[`EBCS_EV_SDRAM] && !wr_mask) |=> sdram_ctrl_interrupt;
  endproperty
  a_sdram_irq: assert property (p_sdram_irq) else $error("sdram interrupt not raised");

  property p_ecc_irq;
    @(posedge clk) disable iff (!arst_n)
    (ecc_src_irq && !ecc_src_q) |=> stat_q[`EBCS_EV_ECC] && (ecc_unit_interrupt == mask_q[`EBCS_EV_ECC]);
  endproperty
  a_ecc_irq: assert property (p_ecc_irq) else $error("ecc event not latched");

  property p_cs5_card;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h5 && cfg_q[`EBCS_CFG_CS5] && ebcs_cf_iord(smc_sig.addr))
      |=> pin_out.rd_n && (pin_out.cf_iord_n == $past(smc_sig.rd_n));
  endproperty
  a_cs5_card: assert property (p_cs5_card) else $error("card i/o read not routed");

  property p_cs4_static;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h4 && !cfg_q[`EBCS_CFG_CS4])
      |=> pin_out.cf_iord_n && pin_out.cfce1_n && (pin_out.rd_n == $past(smc_sig.rd_n));
  endproperty
  a_cs4_static: assert property (p_cs4_static) else $error("static select four misrouted");

  property p_cs3_nand;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h3 && cfg_q[`EBCS_CFG_CS3])
      |=> pin_out.rd_n && (pin_out.nand_oe_n == $past(smc_sig.rd_n));
  endproperty
  a_cs3_nand: assert property (p_cs3_nand) else $error("nand select three misrouted");

  property p_cs2_static;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h2 && !cfg_q[`EBCS_CFG_CS2]) |=> pin_out.nand_oe_n && pin_out.nand_we_n;
  endproperty
  a_cs2_static: assert property (p_cs2_static) else $error("nand strobes active on static");

  property p_cs1_sdram;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h1 && cfg_q[`EBCS_CFG_CS1])
      |=> (pin_out.ras_n == $past(sdr_sig.ras_n)) && (pin_out.ncs_n[1] == $past(sdr_sig.cs_n));
  endproperty
  a_cs1_sdram: assert property (p_cs1_sdram) else $error("sdram pins not routed");

  property p_sdram_en;
    @(posedge clk) disable iff (!arst_n)
    wr_cfg |=> sdram_enable == $past(reg_wdata[`EBCS_CFG_CS1]) ##1 pin_out.sdcke == ($past(sdr_sig.cke) && sdram_enable);
  endproperty
  a_sdram_en: assert property (p_sdram_en) else $error("sdram enable not following bit one");

  property p_reserved;
    @(posedge clk) disable iff (!arst_n)
    (reg_re && reg_addr == `EBCS_OFF_CFG) |=> (reg_rdata[`EBCS_DW-1:6] == '0) && !reg_rdata[0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_cs1_static;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h1 && !cfg_q[`EBCS_CFG_CS1])
      |=> pin_out.ras_n && pin_out.sdwe_n && (pin_out.ncs_n[1] == $past(smc_sig.ncs_n[1]));
  endproperty
  a_cs1_static: assert property (p_cs1_static) else $error("static select one misrouted");

  property p_cs2_nand;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h2 && cfg_q[`EBCS_CFG_CS2])
      |=> pin_out.rd_n && pin_out.we0_n && (pin_out.nand_we_n == $past(smc_sig.we0_n));
  endproperty
  a_cs2_nand: assert property (p_cs2_nand) else $error("nand select two misrouted");

  property p_cs3_static;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h3 && !cfg_q[`EBCS_CFG_CS3])
      |=> pin_out.nand_oe_n && (pin_out.we0_n == $past(smc_sig.we0_n));
  endproperty
  a_cs3_static: assert property (p_cs3_static) else $error("static select three misrouted");

  property p_cs4_card;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h4 && cfg_q[`EBCS_CFG_CS4])
      |=> (pin_out.cfce2_n == $past(smc_sig.we1_n)) && (pin_out.cfrnw == $past(smc_sig.we0_n));
  endproperty
  a_cs4_card: assert property (p_cs4_card) else $error("card select four misrouted");

  property p_cs5_static;
    @(posedge clk) disable iff (!arst_n)
    (acc_valid && acc_sel == 3'h5 && !cfg_q[`EBCS_CFG_CS5])
      |=> pin_out.cf_iord_n && pin_out.cfrnw && (pin_out.rd_n == $past(smc_sig.rd_n));
  endproperty
  a_cs5_static: assert property (p_cs5_static) else $error("static select five misrouted");

  property p_cfg_write;
    @(posedge clk) disable iff (!arst_n)
    wr_cfg |=> cfg_q == ($past(reg_wdata) & `EBCS_CFG_WMASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("assignment write not masked");

  property p_cfg_hold;
    @(posedge clk) disable iff (!arst_n)
    !wr_cfg |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("assignment bits changed without write");

  property p_sleep_ev;
    @(posedge clk) disable iff (!arst_n)
    (sleep_req && acc_valid) |=> stat_q[`EBCS_EV_SLEEP];
  endproperty
  a_sleep_ev: assert property (p_sleep_ev) else $error("sleep during access not flagged");

  property p_cfg_busy;
    @(posedge clk) disable iff (!arst_n)
    (wr_cfg && acc_valid) |=> stat_q[`EBCS_EV_CFGBUSY];
  endproperty
  a_cfg_busy: assert property (p_cfg_busy) else $error("assignment write during access not flagged");

  property p_ecc_clear;
    @(posedge clk) disable iff (!arst_n)
    (wr_stat && reg_wdata[`EBCS_EV_ECC] && !(ecc_src_irq && !ecc_src_q)) |=> !stat_q[`EBCS_EV_ECC];
  endproperty
  a_ecc_clear: assert property (p_ecc_clear) else $error("ecc event not cleared");

  property p_sdcke_off;
    @(posedge clk) disable iff (!arst_n)
    !sdram_enable |=> !pin_out.sdcke;
  endproperty
  a_sdcke_off: assert property (p_sdcke_off) else $error("sdram clock enable without bit one");

  c_sdram_access: cover property (@(posedge clk) disable iff (!arst_n) acc_valid && role == EBCS_ROLE_SDRAM);
  c_nand_access: cover property (@(posedge clk) disable iff (!arst_n) acc_valid && role == EBCS_ROLE_NAND);
  c_card_iord: cover property (@(posedge clk) disable iff (!arst_n)
    acc_valid && role == EBCS_ROLE_CARD && ebcs_cf_iord(smc_sig.addr));
  c_irq_clear: cover property (@(posedge clk) disable iff (!arst_n) ext_bus_irq ##1 wr_stat ##1 !ext_bus_irq);

endmodule

`default_nettype wire

// >>> tb/ebcs_ctrl_model.sv
// far side model: static and sdram controllers driving random traffic
// assumes the bench gates traffic with go and shares clk
`timescale 1ns/100ps
`default_nettype none

module ebcs_ctrl_model import ebcs_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  output logic acc_valid,
  output logic [2:0] acc_sel,
  output ebcs_smc_s static_memory_ctrl,
  output ebcs_sdr_s sdr
);
  integer seed;
  initial seed = 25;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_valid <= 1'b0;
      acc_sel <= 3'h0;
      static_memory_ctrl <= '1;
      sdr <= '1;
    end else if (go) begin
      acc_valid <= 1'($random(seed));
      acc_sel <= 3'($unsigned($random(seed)) % 6);
      static_memory_ctrl <= $bits(static_memory_ctrl)'({$random(seed), $random(seed)});
      sdr <= $bits(sdr)'({$random(seed), $random(seed)});
    end else begin
      // traffic over before sleep or reconfiguration
      acc_valid <= 1'b0;
      static_memory_ctrl <= '1;
      sdr <= '1;
    end
  end
endmodule

`default_nettype wire

// >>> tb/ebcs_top_tb.sv
// bench of the chip select block: register port, interrupts, pin routing
// assumes ebcs_ctrl_model as controllers; one 20 mhz clock
`timescale 1ns/100ps
`default_nettype none
`include "ebcs_defines.svh"

module ebcs_top_tb import ebcs_pkg::*;;
  logic clk, arst_n, reg_we, reg_re, sdram_src_irq, ecc_src_irq, sleep_req, go, av, av_d, chk_on;
  logic slp_m, cfgb_m;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cfg_m;
  logic [2:0] sel;
  ebcs_pin_s exp_pin;
  ebcs_smc_s static_memory_ctrl;
  ebcs_sdr_s sdr;
  ebcs_pin_s pin_out;
  logic sdram_enable, sdram_ctrl_interrupt, ecc_unit_interrupt, ext_bus_irq;
  integer err_total, comparisons, i, k;
  logic [31:0] cfgs [6];

  ebcs_ctrl_model ctrl (.clk(clk), .arst_n(arst_n), .go(go), .acc_valid(av), .acc_sel(sel), .static_memory_ctrl(static_memory_ctrl), .sdr(sdr));
  ebcs_top uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .acc_valid(av), .acc_sel(sel), .smc_sig(static_memory_ctrl), .sdr_sig(sdr),
    .sdram_src_irq(sdram_src_irq), .ecc_src_irq(ecc_src_irq), .sleep_req(sleep_req), .pin_out(pin_out),
    .sdram_enable(sdram_enable), .sdram_ctrl_interrupt(sdram_ctrl_interrupt),
    .ecc_unit_interrupt(ecc_unit_interrupt), .ext_bus_irq(ext_bus_irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic ebcs_pin_s pin_exp(input logic a, input logic [2:0] s, input logic [31:0] c,
    input ebcs_smc_s m, input ebcs_sdr_s d, input logic [23:0] held);
    ebcs_pin_s e;
    e = '1;
    e.addr = held;
    e.sdcke = c[1] & d.cke;
    if (a) begin
      {e.ncs_n, e.rd_n, e.we0_n, e.we1_n, e.addr} = m;
      if (s == 3'h1 && c[1]) begin
        e.ncs_n[1] = d.cs_n;
        e.addr = {d.addr[23:1], d.dqm[0]};
        e.we1_n = d.dqm[1];
        {e.rd_n, e.we0_n} = 2'h3;
        {e.sdwe_n, e.ras_n, e.cas_n} = {d.we_n, d.ras_n, d.cas_n};
      end else if ((s == 3'h2 || s == 3'h3) && c[s]) begin
        {e.nand_oe_n, e.nand_we_n} = {m.rd_n, m.we0_n};
        {e.rd_n, e.we0_n} = 2'h3;
      end else if ((s == 3'h4 || s == 3'h5) && c[s]) begin
        {e.cfce1_n, e.cfce2_n, e.cfrnw} = {m.addr[0], m.we1_n, m.we0_n};
        if (m.addr[23:21] == 3'h4) {e.cf_iord_n, e.rd_n} = {m.rd_n, 1'b1};
      end
    end
    return e;
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input ebcs_pin_s got, input ebcs_pin_s exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD pin t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    chk_reg(reg_rdata & m, e);
    @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // reference model of pins, assignment bits and hazard flags
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_pin <= pin_exp(1'b0, 3'h0, 32'h0000_0000, '1, '1, 24'h00_0000);
      cfg_m <= 32'h0000_0000;
      {av_d, slp_m, cfgb_m} <= 3'h0;
    end else begin
      exp_pin <= pin_exp(av, sel, cfg_m, static_memory_ctrl, sdr, exp_pin.addr);
      av_d <= av;
      if (reg_we && reg_addr == 8'h00) cfg_m <= reg_wdata & 32'h0000_003E;
      if (sleep_req && (av || av_d)) slp_m <= 1'b1;
      if (reg_we && reg_addr == 8'h00 && (av || av_d)) cfgb_m <= 1'b1;
    end
  end

  always @(negedge clk) begin
    if (chk_on) chk_pin(pin_out, exp_pin);
  end

  initial begin
    #(50 * 20000);
    err_total++;
    give_verdict();
  end

  initial begin
    {arst_n, reg_we, reg_re, sdram_src_irq, ecc_src_irq, sleep_req, go, chk_on} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    err_total = 0;
    comparisons = 0;
    k = 25;
    cfgs = '{32'h0000_0000, 32'h0000_003E, 32'h0000_000A, 32'h0000_0014, 32'h0000_0022, 32'h0000_0000};
    cfgs[5] = $random(k) & 32'h0000_003E;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk_on <= 1'b1;
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg(32'(sdram_enable), 32'h0000_0000);
    // interrupt controller set up before the interface
    wr(8'h08, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      if (i == 0) sdram_src_irq <= 1'b1;
      else ecc_src_irq <= 1'b1;
      @(posedge clk);
      {sdram_src_irq, ecc_src_irq} <= 2'h0;
      repeat (2) @(posedge clk);
      chk_reg(32'({ext_bus_irq, ecc_unit_interrupt, sdram_ctrl_interrupt}), 32'h0000_0000);
      rd(8'h04, 32'h0000_000F, 32'(1 << i));
      wr(8'h08, 32'(1 << i));
      chk_reg(32'({ext_bus_irq, ecc_unit_interrupt, sdram_ctrl_interrupt}), 32'(4 | (1 << i)));
      wr(8'h04, 32'(1 << i));
      rd(8'h04, 32'h0000_000F, 32'h0000_0000);
      chk_reg(32'({ext_bus_irq, ecc_unit_interrupt, sdram_ctrl_interrupt}), 32'h0000_0000);
    end
    wr(8'h08, 32'h0000_0003);
    {sdram_src_irq, ecc_src_irq} <= 2'h3;
    @(posedge clk);
    {sdram_src_irq, ecc_src_irq} <= 2'h0;
    repeat (2) @(posedge clk);
    chk_reg(32'({ext_bus_irq, ecc_unit_interrupt, sdram_ctrl_interrupt}), 32'h0000_0007);
    wr(8'h04, 32'h0000_0003);
    chk_reg(32'({ext_bus_irq, ecc_unit_interrupt, sdram_ctrl_interrupt}), 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_003E);
    chk_reg(32'(sdram_enable), 32'h0000_0001);
    rd(8'h0C, 32'h0000_000F, 32'h0000_000F);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    for (i = 0; i < 6; i++) begin
      // assignment written before any access
      wr(8'h00, cfgs[i]);
      rd(8'h00, 32'hFFFF_FFFF, cfgs[i]);
      rd(8'h0C, 32'h0000_000F, {28'h0, cfgs[i][2] | cfgs[i][3], 1'b1, cfgs[i][1], 1'b1});
      chk_reg(32'(sdram_enable), 32'(cfgs[i][1]));
      go <= 1'b1;
      repeat (200) @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
    end
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    rd(8'h04, 32'h0000_0004, 32'h0000_0000);
    go <= 1'b1;
    repeat (10) @(posedge clk);
    wr(8'h00, 32'h0000_003E);
    sleep_req <= 1'b1;
    repeat (3) @(posedge clk);
    {go, sleep_req} <= 2'h0;
    repeat (3) @(posedge clk);
    rd(8'h04, 32'h0000_000C, {28'h0, cfgb_m, slp_m, 2'h0});
    // reset in mid-run with assignment bits set
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg(32'(sdram_enable), 32'h0000_0000);
    give_verdict();
  end
endmodule

`default_nettype wire
